// [core/igmp_filter.sv]
`default_nettype none
module igmp_filter #(
  parameter int N_GROUPS = 8,
  parameter int N_ADDR = 1,
  parameter int TICK_CYCLES = igmp_filter_pkg::TICK_CYCLES
) (
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire igmp_filter_pkg::cfg_t I_CFG,
  input wire igmp_filter_pkg::pkt_t I_RF_PKT,
  input wire igmp_filter_pkg::pkt_t I_CPE_PKT,
  output var igmp_filter_pkg::verdict_t O_RF_VERDICT,
  output var igmp_filter_pkg::verdict_t O_CPE_VERDICT,
  output var igmp_filter_pkg::up_msg_t O_UP_MSG,
  output var igmp_filter_pkg::cpe_query_t O_CPE_QUERY
);

  localparam int GW = igmp_filter_pkg::GRP_W;
  localparam int MW = igmp_filter_pkg::MT_W;
  localparam int RW = igmp_filter_pkg::RSP_W;
  localparam int TW = igmp_filter_pkg::TMR_W;
  localparam int PW = 2 * RW + 1;
  localparam int AI_W = (N_ADDR > 1) ? $clog2(N_ADDR) : 1;

  if (N_GROUPS < 1 || N_GROUPS > (1 << GW) || N_ADDR < 1 || TICK_CYCLES < 2) begin
    $error("igmp_filter: unsupported parameter value");
  end
  // --------------------------------------------------
  // one-second tick and epoch
  // --------------------------------------------------
  logic [31:0] tick_cnt_q;
  logic tick;
  logic [igmp_filter_pkg::SEC_W-1:0] sec_q;
  assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      tick_cnt_q <= '0;
    end else if (tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
    end
  end
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      sec_q <= '0;
    end else if (tick) begin
      sec_q <= sec_q + 16'h1;
    end
  end
  // --------------------------------------------------
  // packet classification
  // --------------------------------------------------
  logic active;
  logic rf_query, rf_rep, cpe_rep, cpe_leave;
  assign active = I_CFG.active;
  assign rf_query = I_RF_PKT.vld && I_RF_PKT.kind == igmp_filter_pkg::PK_QUERY;
  assign rf_rep = I_RF_PKT.vld && I_RF_PKT.kind == igmp_filter_pkg::PK_REPORT;
  assign cpe_rep = I_CPE_PKT.vld && I_CPE_PKT.kind == igmp_filter_pkg::PK_REPORT;
  assign cpe_leave = I_CPE_PKT.vld && I_CPE_PKT.kind == igmp_filter_pkg::PK_LEAVE;
  // --------------------------------------------------
  // query interval learning
  // --------------------------------------------------
  logic q_seen_q;
  logic [igmp_filter_pkg::SEC_W-1:0] last_q_q;
  logic [TW-1:0] mqi_q, gap, mqi_eff;
  logic [RW-1:0] qri_q, qri_eff;
  logic [MW-1:0] memb_int;
  assign gap = sec_q - last_q_q;
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      q_seen_q <= 1'b0;
      last_q_q <= '0;
      mqi_q <= igmp_filter_pkg::MQI_DEF_S;
    end else if (rf_query && !active) begin
      q_seen_q <= 1'b1;
      last_q_q <= sec_q;
      if (q_seen_q) begin
        mqi_q <= (gap > igmp_filter_pkg::MQI_DEF_S) ? gap : igmp_filter_pkg::MQI_DEF_S;
      end
    end
  end
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      qri_q <= igmp_filter_pkg::QRI_DEF_S;
    end else if (rf_query) begin
      qri_q <= (I_RF_PKT.resp_s == '0) ? igmp_filter_pkg::QRI_DEF_S : I_RF_PKT.resp_s;
    end
  end
  assign mqi_eff = (I_CFG.ovr && I_CFG.mqi_s != '0) ? I_CFG.mqi_s : mqi_q;
  assign qri_eff = (I_CFG.ovr && I_CFG.qri_s != '0) ? I_CFG.qri_s : qri_q;
  assign memb_int = MW'({mqi_eff, 1'b0}) + MW'(qri_eff);
  // --------------------------------------------------
  // random delay source
  // --------------------------------------------------
  logic [igmp_filter_pkg::LFSR_W-1:0] lfsr_q;
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      lfsr_q <= igmp_filter_pkg::LFSR_SEED;
    end else begin
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    end
  end
  // product scaling keeps the result inside 0..mx without a divider
  function automatic logic [RW-1:0] scale(input logic [RW-1:0] rnd, input logic [RW-1:0] mx);
    logic [PW-1:0] p;
    p = PW'(rnd) * (PW'(mx) + PW'(1));
    return p[2*RW-1:RW];
  endfunction
  // --------------------------------------------------
  // per-group state
  // --------------------------------------------------
  logic [MW-1:0] memb_q [N_GROUPS];
  logic [RW-1:0] rnd_q [N_GROUPS];
  logic [N_GROUPS-1:0] hold_q, supp_q, member, gnt;
  logic exp_any, rf_member;
  logic [GW-1:0] exp_idx;
  // a leave owns the upstream slot; expiries simply wait a cycle
  always_comb begin
    exp_any = 1'b0;
    exp_idx = '0;
    for (int g = N_GROUPS - 1; g >= 0; g--) begin
      member[g] = memb_q[g] != '0;
      if (hold_q[g] && rnd_q[g] == '0) begin
        exp_any = 1'b1;
        exp_idx = GW'(g);
      end
    end
    for (int g = 0; g < N_GROUPS; g++) begin
      gnt[g] = exp_any && !cpe_leave && exp_idx == GW'(g);
    end
  end
  assign rf_member = (int'(I_RF_PKT.grp) < N_GROUPS) && member[I_RF_PKT.grp];
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      for (int g = 0; g < N_GROUPS; g++) begin
        memb_q[g] <= '0;
      end
    end else begin
      for (int g = 0; g < N_GROUPS; g++) begin
        if (cpe_rep && I_CPE_PKT.grp == GW'(g)) begin
          memb_q[g] <= memb_int;
        end else if (cpe_leave && I_CPE_PKT.grp == GW'(g)) begin
          memb_q[g] <= (memb_q[g] > MW'(qri_eff)) ? MW'(qri_eff) : memb_q[g];
        end else if (tick && memb_q[g] != '0) begin
          memb_q[g] <= memb_q[g] - MW'(1);
        end
      end
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      hold_q <= '0;
      for (int g = 0; g < N_GROUPS; g++) begin
        rnd_q[g] <= '0;
      end
    end else begin
      for (int g = 0; g < N_GROUPS; g++) begin
        if (gnt[g]) begin
          hold_q[g] <= 1'b0;
        end else if (hold_q[g] && rf_rep && I_RF_PKT.grp == GW'(g)) begin
          hold_q[g] <= 1'b0;
        end else if (!hold_q[g] && cpe_rep && I_CPE_PKT.grp == GW'(g) && !(active && supp_q[g])) begin
          hold_q[g] <= 1'b1;
          rnd_q[g] <= scale(lfsr_q[RW-1:0],
                            active ? igmp_filter_pkg::JOIN_QRI_S : igmp_filter_pkg::PASSIVE_RND_MAX_S);
        end else if (!hold_q[g] && active && member[g] && rf_query
                     && (I_RF_PKT.all_hosts || I_RF_PKT.grp == GW'(g))) begin
          hold_q[g] <= 1'b1;
          rnd_q[g] <= scale(lfsr_q[RW-1:0], qri_eff);
        end else if (hold_q[g] && tick && rnd_q[g] != '0) begin
          rnd_q[g] <= rnd_q[g] - RW'(1);
        end
      end
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      supp_q <= '0;
    end else begin
      for (int g = 0; g < N_GROUPS; g++) begin
        if (active && member[g] && rf_rep && I_RF_PKT.grp == GW'(g)) begin
          supp_q[g] <= 1'b1;
        end else if (rf_query && (I_RF_PKT.all_hosts || I_RF_PKT.grp == GW'(g))) begin
          supp_q[g] <= 1'b0;
        end else if (cpe_leave && I_CPE_PKT.grp == GW'(g)) begin
          supp_q[g] <= 1'b0;
        end
      end
    end
  end

  // --------------------------------------------------
  // upstream messages
  // --------------------------------------------------
  // only reports and leaves, never queries
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      O_UP_MSG <= '0;
    end else if (cpe_leave) begin
      O_UP_MSG.vld <= 1'b1;
      O_UP_MSG.leave <= 1'b1;
      O_UP_MSG.grp <= I_CPE_PKT.grp;
    end else if (exp_any) begin
      O_UP_MSG.vld <= 1'b1;
      O_UP_MSG.leave <= 1'b0;
      O_UP_MSG.grp <= exp_idx;
    end else begin
      O_UP_MSG <= '0;
    end
  end
  // --------------------------------------------------
  // customer-side querier
  // --------------------------------------------------
  logic [TW-1:0] qry_tmr_q;
  logic gen_due;
  assign gen_due = active && qry_tmr_q == '0 && !cpe_leave;
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      qry_tmr_q <= '0;
    end else if (!active) begin
      qry_tmr_q <= '0;
    end else if (gen_due) begin
      qry_tmr_q <= mqi_eff;
    end else if (tick && qry_tmr_q != '0) begin
      qry_tmr_q <= qry_tmr_q - TW'(1);
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      O_CPE_QUERY <= '0;
    end else if (active && cpe_leave) begin
      O_CPE_QUERY.vld <= 1'b1;
      O_CPE_QUERY.general <= 1'b0;
      O_CPE_QUERY.grp <= I_CPE_PKT.grp;
    end else if (gen_due) begin
      O_CPE_QUERY.vld <= 1'b1;
      O_CPE_QUERY.general <= 1'b1;
      O_CPE_QUERY.grp <= '0;
    end else begin
      O_CPE_QUERY <= '0;
    end
  end
  // --------------------------------------------------
  // customer source address table
  // --------------------------------------------------
  logic [igmp_filter_pkg::MAC_W-1:0] addr_q [N_ADDR];
  logic [N_ADDR-1:0] addr_v_q;
  logic addr_hit, free_any;
  logic [AI_W-1:0] free_idx;
  always_comb begin
    addr_hit = 1'b0;
    free_any = 1'b0;
    free_idx = '0;
    for (int a = N_ADDR - 1; a >= 0; a--) begin
      if (addr_v_q[a] && addr_q[a] == I_CPE_PKT.src) begin
        addr_hit = 1'b1;
      end
      if (!addr_v_q[a]) begin
        free_any = 1'b1;
        free_idx = AI_W'(a);
      end
    end
  end
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      addr_v_q <= '0;
      for (int a = 0; a < N_ADDR; a++) begin
        addr_q[a] <= '0;
      end
    end else if (I_CPE_PKT.vld && !addr_hit && free_any) begin
      addr_v_q[free_idx] <= 1'b1;
      addr_q[free_idx] <= I_CPE_PKT.src;
    end
  end
  // --------------------------------------------------
  // forwarding verdicts
  // --------------------------------------------------
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      O_RF_VERDICT <= '0;
    end else begin
      O_RF_VERDICT.vld <= I_RF_PKT.vld;
      case (I_RF_PKT.kind)
        igmp_filter_pkg::PK_QUERY: begin
          // all-hosts queries pass in passive mode
          O_RF_VERDICT.fwd <= !active && I_RF_PKT.all_hosts && !I_CFG.admin_dn_block;
        end
        igmp_filter_pkg::PK_DATA: begin
          O_RF_VERDICT.fwd <= (I_RF_PKT.all_hosts || rf_member) && !I_CFG.admin_dn_block;
        end
        default: begin
          // reports and leaves stay on coax side
          O_RF_VERDICT.fwd <= 1'b0;
        end
      endcase
    end
  end
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      O_CPE_VERDICT <= '0;
    end else begin
      O_CPE_VERDICT.vld <= I_CPE_PKT.vld;
      case (I_CPE_PKT.kind)
        igmp_filter_pkg::PK_DATA: begin
          // upstream unless admin-blocked or a new source finds the address table full
          O_CPE_VERDICT.fwd <= !I_CFG.admin_up_block && (addr_hit || free_any);
        end
        default: begin
          // queries dropped; reports go through the hold path
          O_CPE_VERDICT.fwd <= 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// [core/igmp_filter_pkg.sv]
`default_nettype none
package igmp_filter_pkg;

  // --------------------------------------------------
  // clock and one-second tick
  // --------------------------------------------------
  localparam int CLK_MHZ = 32'hc8;
  localparam int TICK_PERIOD_MS = 32'h3e8;
  localparam int TICK_CYCLES = TICK_PERIOD_MS * 32'h3e8 * CLK_MHZ;

  // --------------------------------------------------
  // widths
  // --------------------------------------------------
  localparam int SEC_W = 16;
  localparam int TMR_W = 16;
  localparam int MT_W = TMR_W + 2;
  localparam int RSP_W = 8;
  localparam int GRP_W = 3;
  localparam int MAC_W = 48;
  localparam int LFSR_W = 16;

  // --------------------------------------------------
  // timer defaults, in seconds, and the LFSR seed
  // --------------------------------------------------
  localparam logic [TMR_W-1:0] MQI_DEF_S = 16'h007d;
  localparam logic [RSP_W-1:0] QRI_DEF_S = 8'h0a;
  localparam logic [RSP_W-1:0] PASSIVE_RND_MAX_S = 8'h03;
  localparam logic [RSP_W-1:0] JOIN_QRI_S = 8'h03;
  localparam logic [LFSR_W-1:0] LFSR_SEED = 16'hace1;

  // --------------------------------------------------
  // types
  // --------------------------------------------------
  typedef enum logic [2:0] {
    PK_NONE,
    PK_QUERY,
    PK_REPORT,
    PK_LEAVE,
    PK_DATA
  } pkt_kind_t;

  typedef struct packed {
    logic vld;
    pkt_kind_t kind;
    logic [GRP_W-1:0] grp;
    logic all_hosts;
    logic [RSP_W-1:0] resp_s;
    logic [MAC_W-1:0] src;
  } pkt_t;

  typedef struct packed {
    logic vld;
    logic fwd;
  } verdict_t;

  typedef struct packed {
    logic vld;
    logic leave;
    logic [GRP_W-1:0] grp;
  } up_msg_t;

  typedef struct packed {
    logic vld;
    logic general;
    logic [GRP_W-1:0] grp;
  } cpe_query_t;

  typedef struct packed {
    logic active;
    logic admin_up_block;
    logic admin_dn_block;
    logic ovr;
    logic [TMR_W-1:0] mqi_s;
    logic [RSP_W-1:0] qri_s;
  } cfg_t;

endpackage
`default_nettype wire

// [dv/far_side_model.sv]
`default_nettype none
module far_side_model (
  input wire logic i_clk,
  input wire igmp_filter_pkg::verdict_t i_rf_v,
  input wire igmp_filter_pkg::verdict_t i_cpe_v,
  output var igmp_filter_pkg::pkt_t o_rf_pkt,
  output var igmp_filter_pkg::pkt_t o_cpe_pkt
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_rf_pkt = '0;
    o_cpe_pkt = '0;
  end
  // ----
  // one packet per call
  // ----
  // idle fields are scrambled so a stale packet never looks meaningful
  task automatic send(input logic rf, input igmp_filter_pkg::pkt_t p, output igmp_filter_pkg::verdict_t v);
    igmp_filter_pkg::pkt_t idle;
    idle = ~p;
    idle.vld = 1'b0;
    @(posedge i_clk);
    #1;
    if (rf) o_rf_pkt = p;
    else o_cpe_pkt = p;
    @(posedge i_clk);
    #1;
    v = rf ? i_rf_v : i_cpe_v;
    if (rf) o_rf_pkt = idle;
    else o_cpe_pkt = idle;
  endtask
endmodule
`default_nettype wire

// [dv/igmp_filter_props.sv]
`default_nettype none
module igmp_filter_props (
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire igmp_filter_pkg::cfg_t I_CFG,
  input wire igmp_filter_pkg::pkt_t I_RF_PKT,
  input wire igmp_filter_pkg::pkt_t I_CPE_PKT,
  input wire igmp_filter_pkg::verdict_t O_RF_VERDICT,
  input wire igmp_filter_pkg::verdict_t O_CPE_VERDICT,
  input wire igmp_filter_pkg::up_msg_t O_UP_MSG,
  input wire igmp_filter_pkg::cpe_query_t O_CPE_QUERY
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_RST);
  // ----
  // verdict timing, direction filters, leave relay and customer queries
  // ----
  chk_rf_answer_lat: assert property (
    I_RF_PKT.vld |=> O_RF_VERDICT.vld) else $error("coax verdict missing one cycle after packet");
  chk_cpe_answer_src: assert property (
    O_CPE_VERDICT.vld |-> $past(I_CPE_PKT.vld)) else $error("customer verdict without a packet");
  chk_cpe_query_blk: assert property (
    I_CPE_PKT.vld && I_CPE_PKT.kind == igmp_filter_pkg::PK_QUERY |=> O_CPE_VERDICT.vld && !O_CPE_VERDICT.fwd)
    else $error("customer query passed upstream");
  chk_rf_report_blk: assert property (
    I_RF_PKT.vld && I_RF_PKT.kind inside {igmp_filter_pkg::PK_REPORT, igmp_filter_pkg::PK_LEAVE}
    |=> !O_RF_VERDICT.fwd) else $error("coax report or leave passed down");
  chk_dn_admin_blk: assert property (
    I_RF_PKT.vld && I_CFG.admin_dn_block |=> !O_RF_VERDICT.fwd) else $error("blocked coax traffic passed");
  chk_up_admin_blk: assert property (
    I_CPE_PKT.vld && I_CFG.admin_up_block |=> !O_CPE_VERDICT.fwd) else $error("blocked customer data passed");
  chk_all_hosts_fwd: assert property (
    I_RF_PKT.vld && I_RF_PKT.all_hosts && !I_CFG.active && !I_CFG.admin_dn_block
    && I_RF_PKT.kind inside {igmp_filter_pkg::PK_DATA, igmp_filter_pkg::PK_QUERY}
    |=> O_RF_VERDICT.fwd) else $error("all-hosts traffic dropped");
  chk_leave_up_msg: assert property (
    I_CPE_PKT.vld && I_CPE_PKT.kind == igmp_filter_pkg::PK_LEAVE
    |=> O_UP_MSG.vld && O_UP_MSG.leave && O_UP_MSG.grp == $past(I_CPE_PKT.grp)) else $error("leave not relayed");
  chk_active_no_fwdq: assert property (
    I_RF_PKT.vld && I_RF_PKT.kind == igmp_filter_pkg::PK_QUERY && I_CFG.active
    |=> !O_RF_VERDICT.fwd) else $error("coax query passed in active mode");
  chk_passive_no_query: assert property (
    !I_CFG.active ##1 !I_CFG.active |-> !O_CPE_QUERY.vld) else $error("query sent in passive mode");
  chk_leave_grp_qry: assert property (
    I_CPE_PKT.vld && I_CPE_PKT.kind == igmp_filter_pkg::PK_LEAVE && I_CFG.active
    |=> O_CPE_QUERY.vld && !O_CPE_QUERY.general && O_CPE_QUERY.grp == $past(I_CPE_PKT.grp))
    else $error("leave did not trigger a group query");
endmodule

bind igmp_filter igmp_filter_props u_props (.I_MCLK(I_MCLK), .I_RST(I_RST), .I_CFG(I_CFG),
  .I_RF_PKT(I_RF_PKT), .I_CPE_PKT(I_CPE_PKT), .O_RF_VERDICT(O_RF_VERDICT),
  .O_CPE_VERDICT(O_CPE_VERDICT), .O_UP_MSG(O_UP_MSG), .O_CPE_QUERY(O_CPE_QUERY));
`default_nettype wire

// [dv/tb_igmp_filter.sv]
`default_nettype none
module tb_igmp_filter;
  timeunit 1ns;
  timeprecision 1ps;
  // short tick keeps second-based timers within a few thousand cycles
  localparam int TK = 20;
  logic I_MCLK;
  logic I_RST;
  igmp_filter_pkg::cfg_t cfg;
  igmp_filter_pkg::pkt_t rf_pkt;
  igmp_filter_pkg::pkt_t cpe_pkt;
  igmp_filter_pkg::verdict_t rf_v;
  igmp_filter_pkg::verdict_t cpe_v;
  igmp_filter_pkg::up_msg_t up;
  igmp_filter_pkg::cpe_query_t cq;
  igmp_filter_pkg::verdict_t v;
  int err_count;
  int tests_run;
  int c;

  far_side_model u_far (.i_clk(I_MCLK), .i_rf_v(rf_v), .i_cpe_v(cpe_v), .o_rf_pkt(rf_pkt), .o_cpe_pkt(cpe_pkt));
  igmp_filter #(.N_GROUPS(8), .N_ADDR(1), .TICK_CYCLES(TK)) u_dut (.I_MCLK(I_MCLK), .I_RST(I_RST), .I_CFG(cfg),
    .I_RF_PKT(rf_pkt), .I_CPE_PKT(cpe_pkt), .O_RF_VERDICT(rf_v), .O_CPE_VERDICT(cpe_v), .O_UP_MSG(up),
    .O_CPE_QUERY(cq));

  initial begin
    I_MCLK = 1'b0;
    forever #2.5 I_MCLK = ~I_MCLK;
  end

  // ----
  // helpers
  // ----
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      err_count++;
    end
  endtask

  task automatic tx(input logic rf, input igmp_filter_pkg::pkt_kind_t k, input logic [igmp_filter_pkg::GRP_W-1:0] g,
      input logic ah = 1'b0, input logic [7:0] r = 8'h00, input logic [47:0] s = 48'h0);
    u_far.send(rf, '{vld: 1'b1, kind: k, grp: g, all_hosts: ah, resp_s: r, src: s}, v);
    check("verdict valid", 1'h1, v.vld);
  endtask

  // counts upstream reports for one group over n cycles
  task automatic watch(input int n, input logic [igmp_filter_pkg::GRP_W-1:0] g);
    c = 0;
    for (int i = 0; i < n; i++) begin
      @(posedge I_MCLK);
      #1;
      if (up.vld === 1'b1 && up.leave === 1'b0 && up.grp === g) c++;
    end
  endtask

  task automatic do_reset();
    I_RST = 1'b1;
    repeat (16) @(posedge I_MCLK);
    #1 I_RST = 1'b0;
  endtask

  task automatic expire(input logic [igmp_filter_pkg::GRP_W-1:0] g, input int secs);
    tx(0, igmp_filter_pkg::PK_REPORT, g);
    repeat ((secs - 2) * TK) @(posedge I_MCLK);
    tx(1, igmp_filter_pkg::PK_DATA, g);
    check("member before expiry", 1'h1, v.fwd);
    repeat (4 * TK) @(posedge I_MCLK);
    tx(1, igmp_filter_pkg::PK_DATA, g);
    check("member after expiry", 1'h0, v.fwd);
    $display("test expiry done");
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_basic();
    tx(1, igmp_filter_pkg::PK_DATA, 2);
    check("non-member data", 1'h0, v.fwd);
    tx(1, igmp_filter_pkg::PK_DATA, 2, 1);
    check("all-hosts data", 1'h1, v.fwd);
    tx(1, igmp_filter_pkg::PK_QUERY, 0, 1);
    check("all-hosts query", 1'h1, v.fwd);
    tx(1, igmp_filter_pkg::PK_REPORT, 2);
    check("coax report", 1'h0, v.fwd);
    tx(1, igmp_filter_pkg::PK_LEAVE, 2);
    check("coax leave", 1'h0, v.fwd);
    tx(0, igmp_filter_pkg::PK_QUERY, 2, 1);
    check("customer query", 1'h0, v.fwd);
    $display("test basic done");
  endtask

  task automatic t_join();
    tx(0, igmp_filter_pkg::PK_REPORT, 1);
    tx(0, igmp_filter_pkg::PK_REPORT, 1);
    watch(4 * TK + 4, 1);
    check("held reports sent", 1'h1, c);
    tx(1, igmp_filter_pkg::PK_DATA, 1);
    check("joined group data", 1'h1, v.fwd);
    tx(0, igmp_filter_pkg::PK_REPORT, 3);
    tx(1, igmp_filter_pkg::PK_REPORT, 3);
    watch(4 * TK + 4, 3);
    check("cancelled report", 1'h0, c);
    $display("test join done");
  endtask

  task automatic t_leave();
    tx(1, igmp_filter_pkg::PK_QUERY, 0, 1, 8'h04);
    tx(0, igmp_filter_pkg::PK_REPORT, 5);
    tx(0, igmp_filter_pkg::PK_LEAVE, 5);
    check("leave upstream", {1'h1, 1'h1, 3'h5}, {up.vld, up.leave, up.grp});
    repeat (2 * TK) @(posedge I_MCLK);
    tx(1, igmp_filter_pkg::PK_DATA, 5);
    check("inside response window", 1'h1, v.fwd);
    repeat (4 * TK) @(posedge I_MCLK);
    tx(1, igmp_filter_pkg::PK_DATA, 5);
    check("after response window", 1'h0, v.fwd);
    $display("test leave done");
  endtask

  task automatic t_addr();
    // earlier scenarios already filled the single source slot
    do_reset();
    tx(0, igmp_filter_pkg::PK_DATA, 0, 0, 8'h00, 48'ha1);
    check("first source", 1'h1, v.fwd);
    tx(0, igmp_filter_pkg::PK_DATA, 0, 0, 8'h00, 48'hb2);
    check("second source", 1'h0, v.fwd);
    cfg.admin_up_block = 1'b1;
    tx(0, igmp_filter_pkg::PK_DATA, 0, 0, 8'h00, 48'ha1);
    check("admin up block", 1'h0, v.fwd);
    cfg = '0;
    cfg.admin_dn_block = 1'b1;
    tx(1, igmp_filter_pkg::PK_DATA, 0, 1);
    check("admin down block", 1'h0, v.fwd);
    cfg = '0;
    do_reset();
    tx(0, igmp_filter_pkg::PK_DATA, 0, 0, 8'h00, 48'hb2);
    check("table cleared", 1'h1, v.fwd);
    $display("test address done");
  endtask

  task automatic t_active();
    cfg.active = 1'b1;
    c = 0;
    repeat (4) begin
      @(posedge I_MCLK);
      #1;
      if (cq.vld === 1'b1 && cq.general === 1'b1) c++;
    end
    check("general query", 1'h1, c);
    tx(0, igmp_filter_pkg::PK_REPORT, 6);
    watch(4 * TK + 4, 6);
    check("join report", 1'h1, c);
    tx(1, igmp_filter_pkg::PK_REPORT, 6);
    tx(0, igmp_filter_pkg::PK_REPORT, 6);
    watch(4 * TK + 4, 6);
    check("suppressed report", 1'h0, c);
    tx(1, igmp_filter_pkg::PK_QUERY, 0, 1, 8'h02);
    check("active query held", 1'h0, v.fwd);
    watch(12 * TK, 6);
    check("report after query", 1'h1, c);
    tx(1, igmp_filter_pkg::PK_REPORT, 6);
    tx(0, igmp_filter_pkg::PK_LEAVE, 6);
    check("group query", {1'h1, 1'h0, 3'h6}, {cq.vld, cq.general, cq.grp});
    tx(0, igmp_filter_pkg::PK_REPORT, 6);
    watch(4 * TK + 4, 6);
    check("report after leave", 1'h1, c);
    cfg.active = 1'b0;
    $display("test active done");
  endtask

  initial begin
    repeat (20000) @(posedge I_MCLK);
    $display("watchdog expired");
    err_count++;
    wrap_up();
  end

  initial begin
    I_RST = 1'b1;
    cfg = '0;
    err_count = 0;
    tests_run = 0;
    do_reset();
    t_basic();
    t_join();
    expire(4, 260);
    t_leave();
    cfg.ovr = 1'b1;
    cfg.mqi_s = 16'h000a;
    cfg.qri_s = 8'h05;
    expire(7, 25);
    cfg = '0;
    t_addr();
    t_active();
    wrap_up();
  end
endmodule
`default_nettype wire
